// *** hdl/flash_map_pkg.sv ***
// flash map package: address windows, page codes, config field, protection fields
// assumes a 16-bit logical address bus and a 6-bit page select value
package flash_map_pkg;
	localparam logic [15:0] WIN_LOW_BASE = 16'h4000;
	localparam logic [15:0] WIN_MID_BASE = 16'h8000;
	localparam logic [15:0] WIN_HIGH_BASE = 16'hC000;
	localparam logic [5:0] PAGE_MIN = 6'h38;
	localparam logic [5:0] PAGE_MAX = 6'h3F;
	localparam logic [5:0] PAGE_LOW_FIXED = 6'h3E;
	localparam logic [5:0] PAGE_HIGH_FIXED = 6'h3F;
	localparam int ARRAY_AW = 17;
	localparam logic [16:0] KEY_BASE = 17'h1FF00;
	localparam logic [16:0] KEY_LAST = 17'h1FF07;
	localparam logic [16:0] PROT_BYTE_ADDR = 17'h1FF0D;
	localparam logic [16:0] SEC_BYTE_ADDR = 17'h1FF0F;
	localparam logic [16:0] RSVD_A_FIRST = 17'h1FF08;
	localparam logic [16:0] RSVD_A_LAST = 17'h1FF0C;
	localparam logic [16:0] RSVD_B_ADDR = 17'h1FF0E;
	// lower area starts at array offset of page 0x3E
	localparam logic [16:0] LOW_AREA_BASE = 17'h18000;
	localparam logic [16:0] ARRAY_END = 17'h1FFFF;
	// protection byte fields
	localparam int PROT_OPEN_BIT = 7;
	localparam int PROT_HDIS_BIT = 5;
	localparam int PROT_HS_LSB = 3;
	localparam int PROT_LDIS_BIT = 2;
	localparam int PROT_LS_LSB = 0;
	localparam logic [7:0] PROT_RESET = 8'hFF;
	localparam logic [7:0] SEC_RESET = 8'hFF;
	localparam int LOAD_BYTES = 2;

	typedef struct packed {
		logic valid;
		logic [16:0] array_addr;
		logic prot_hit;
		logic in_low_area;
		logic in_high_area;
		logic in_key;
		logic in_prot_byte;
		logic in_sec_byte;
		logic in_reserved;
	} decode_s;

	typedef enum logic [1:0] {ST_RESET, ST_LOAD_PROT, ST_LOAD_SEC, ST_RUN} load_e;
endpackage

// *** hdl/flash_prot_check.sv ***
// protection area check on an array-relative address
// assumes the protection byte is stable while checked
`timescale 1ns/1ps
module flash_prot_check
(
	// address and settings
	input wire logic [16:0] array_addr_i,
	input wire logic [7:0] prot_i,
	// results
	output logic low_o,
	output logic high_o,
	output logic hit_o
);
	logic [16:0] low_top;
	logic [16:0] high_bot;
	logic open_all;
	always_comb
	begin
		// lower area 1K, 2K, 4K, 8K from base
		case (prot_i[flash_map_pkg::PROT_LS_LSB +: 2])
			2'h0: low_top = flash_map_pkg::LOW_AREA_BASE + 17'h003FF;
			2'h1: low_top = flash_map_pkg::LOW_AREA_BASE + 17'h007FF;
			2'h2: low_top = flash_map_pkg::LOW_AREA_BASE + 17'h00FFF;
			default: low_top = flash_map_pkg::LOW_AREA_BASE + 17'h01FFF;
		endcase
		// higher area 2K, 4K, 8K, 16K down from end
		case (prot_i[flash_map_pkg::PROT_HS_LSB +: 2])
			2'h0: high_bot = flash_map_pkg::ARRAY_END - 17'h007FF;
			2'h1: high_bot = flash_map_pkg::ARRAY_END - 17'h00FFF;
			2'h2: high_bot = flash_map_pkg::ARRAY_END - 17'h01FFF;
			default: high_bot = flash_map_pkg::ARRAY_END - 17'h03FFF;
		endcase
		low_o = !prot_i[flash_map_pkg::PROT_LDIS_BIT] && array_addr_i >= flash_map_pkg::LOW_AREA_BASE
			&& array_addr_i <= low_top;
		high_o = !prot_i[flash_map_pkg::PROT_HDIS_BIT] && array_addr_i >= high_bot;
		// open bit clear protects everything outside areas too; whole-array protection
		open_all = !prot_i[flash_map_pkg::PROT_OPEN_BIT];
		hit_o = open_all || low_o || high_o;
	end
endmodule

// *** hdl/flash_map_decode.sv ***
// flash map and protection decode for a 128 Kbyte array
// assumes the core supplies the logical address and page select on the same clock
// Operation
// - no off-chip pins; on-chip bus only
// - decode 0x4000-0xFFFF as three windows
// - middle window uses page select value
// - pages 0x38-0x3F map successive slices
// - fixed windows alias pages 0x3E, 0x3F
// - whole-array protection blocks program, erase
// - lower area from base, four sizes
// - higher area down from end, four sizes
// - key held at 0xFF00-0xFF07
// - protect byte 0xFF0D, security 0xFF0F
// - load protection, security at reset, hold core
`timescale 1ns/1ps
module flash_map_decode
(
	// clock and reset
	input wire logic ref_clk_i,
	input wire logic rstn_i,
	// core access, same clock
	input wire logic req_i,
	input wire logic [15:0] addr_i,
	input wire logic [5:0] page_select_register_i,
	// array read port for configuration load
	output logic cfg_rd_o,
	output logic [16:0] cfg_addr_o,
	input wire logic [7:0] cfg_data_i,
	// results
	output logic hold_core_o,
	output flash_map_pkg::decode_s dec_o,
	output logic [7:0] array_protection_register_o,
	output logic [7:0] array_security_register_o
);
	// ****************************************
	// state
	// ****************************************
	typedef struct packed {
		flash_map_pkg::load_e st;
		logic [7:0] prot;
		logic [7:0] sec;
		logic rd;
		logic [16:0] rd_addr;
		logic hold;
		flash_map_pkg::decode_s dec;
	} state_s;

	state_s q;
	state_s d;
	flash_map_pkg::decode_s cur;
	logic [16:0] taddr;
	logic win_ok;
	logic p_low;
	logic p_high;
	logic p_hit;

	// ****************************************
	// translation
	// ****************************************
	always_comb
	begin
		taddr = '0;
		win_ok = 1'b0;
		// nothing here reaches a pin; all inputs are on-chip signals
		case (addr_i[15:14])
			2'h1:
			begin
				taddr = {flash_map_pkg::PAGE_LOW_FIXED[2:0], addr_i[13:0]};
				win_ok = 1'b1;
			end
			2'h2:
			begin
				taddr = {page_select_register_i[2:0], addr_i[13:0]};
				win_ok = page_select_register_i >= flash_map_pkg::PAGE_MIN;
			end
			2'h3:
			begin
				taddr = {flash_map_pkg::PAGE_HIGH_FIXED[2:0], addr_i[13:0]};
				win_ok = 1'b1;
			end
			default:
			begin
				taddr = '0;
				win_ok = 1'b0;
			end
		endcase
	end

	flash_prot_check u_check
	(
		.array_addr_i(taddr),
		.prot_i(q.prot),
		.low_o(p_low),
		.high_o(p_high),
		.hit_o(p_hit)
	);

	always_comb
	begin
		cur.valid = req_i && win_ok && q.st == flash_map_pkg::ST_RUN;
		cur.array_addr = taddr;
		cur.prot_hit = cur.valid && p_hit;
		cur.in_low_area = cur.valid && p_low;
		cur.in_high_area = cur.valid && p_high;
		cur.in_key = cur.valid && taddr >= flash_map_pkg::KEY_BASE && taddr <= flash_map_pkg::KEY_LAST;
		cur.in_prot_byte = cur.valid && taddr == flash_map_pkg::PROT_BYTE_ADDR;
		cur.in_sec_byte = cur.valid && taddr == flash_map_pkg::SEC_BYTE_ADDR;
		cur.in_reserved = cur.valid && ((taddr >= flash_map_pkg::RSVD_A_FIRST
			&& taddr <= flash_map_pkg::RSVD_A_LAST) || taddr == flash_map_pkg::RSVD_B_ADDR);
	end

	// ****************************************
	// reset load sequence
	// ****************************************
	always_comb
	begin
		d = q;
		d.dec = cur;
		d.rd = 1'b0;
		case (q.st)
			flash_map_pkg::ST_RESET:
			begin
				d.rd = 1'b1;
				d.rd_addr = flash_map_pkg::PROT_BYTE_ADDR;
				d.st = flash_map_pkg::ST_LOAD_PROT;
			end
			flash_map_pkg::ST_LOAD_PROT:
			begin
				d.prot = cfg_data_i;
				d.rd = 1'b1;
				d.rd_addr = flash_map_pkg::SEC_BYTE_ADDR;
				d.st = flash_map_pkg::ST_LOAD_SEC;
			end
			flash_map_pkg::ST_LOAD_SEC:
			begin
				d.sec = cfg_data_i;
				d.hold = 1'b0;
				d.st = flash_map_pkg::ST_RUN;
			end
			flash_map_pkg::ST_RUN:
			begin
				d.hold = 1'b0;
			end
			default:
			begin
				d.st = flash_map_pkg::ST_RESET;
				d.hold = 1'b1;
			end
		endcase
	end

	always_ff @(posedge ref_clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			q.st <= flash_map_pkg::ST_RESET;
			q.prot <= flash_map_pkg::PROT_RESET;
			q.sec <= flash_map_pkg::SEC_RESET;
			q.rd <= 1'b0;
			q.rd_addr <= '0;
			q.hold <= 1'b1;
			q.dec <= '0;
		end
		else
		begin
			q <= d;
		end
	end

	assign cfg_rd_o = q.rd;
	assign cfg_addr_o = q.rd_addr;
	assign hold_core_o = q.hold;
	assign dec_o = q.dec;
	assign array_protection_register_o = q.prot;
	assign array_security_register_o = q.sec;

	// ****************************************
	// checks
	// ****************************************
	hold_release_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
		$fell(q.hold) |-> $past(q.st) == flash_map_pkg::ST_LOAD_SEC)
		else $error("core released before config load");
	no_dec_hold_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
		q.hold |=> !q.dec.valid)
		else $error("decode valid while core held");
	mid_page_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
		cur.valid && addr_i[15:14] == 2'h2 |=> q.dec.array_addr[16:14] == $past(page_select_register_i[2:0]))
		else $error("paged window maps wrong slice");
	fixed_high_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
		cur.valid && addr_i[15:14] == 2'h3 |=> q.dec.array_addr == {3'h7, $past(addr_i[13:0])})
		else $error("fixed high window alias wrong");
	fixed_low_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
		cur.valid && addr_i[15:14] == 2'h1 |=> q.dec.array_addr[16:14] == 3'h6)
		else $error("fixed low window alias wrong");
	below_window_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
		req_i && addr_i < flash_map_pkg::WIN_LOW_BASE |=> !q.dec.valid)
		else $error("address below window decoded");
	bad_page_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
		req_i && addr_i[15:14] == 2'h2 && page_select_register_i < 6'h38 |=> !q.dec.valid)
		else $error("invalid page decoded");
	whole_prot_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
		cur.valid && !q.prot[7] |=> q.dec.prot_hit)
		else $error("whole array protection missed");
	key_area_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
		cur.valid && addr_i[15:3] == 13'h1FE0 |=> q.dec.in_key)
		else $error("key region not flagged");
	sec_byte_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
		cur.valid && addr_i == 16'hFF0F |=> q.dec.in_sec_byte && !q.dec.in_reserved)
		else $error("security byte not flagged");
	alias_prot_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
		cur.valid && addr_i[15:14] == 2'h2 && page_select_register_i == 6'h3F && q.prot[5] == 1'b0
		&& addr_i[13:11] == 3'h7 |=> q.dec.in_high_area)
		else $error("paged alias escapes higher area");
	prot_read_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
		q.st == flash_map_pkg::ST_LOAD_PROT |-> q.rd && q.rd_addr == flash_map_pkg::PROT_BYTE_ADDR)
		else $error("protection byte read missing");
	sec_read_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
		q.st == flash_map_pkg::ST_LOAD_SEC |-> q.rd && q.rd_addr == flash_map_pkg::SEC_BYTE_ADDR)
		else $error("security byte read missing");
	low_area_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
		cur.valid && !q.prot[flash_map_pkg::PROT_LDIS_BIT] && addr_i[15:10] == 6'h10 |=> q.dec.in_low_area)
		else $error("smallest lower area not flagged");
endmodule

// *** bench/cfg_field_model.sv ***
// array-side source of the configuration field bytes read at reset
// assumes the read data is taken in the same cycle as the strobe
`timescale 1ns/1ps
module cfg_field_model
(
	// clock
	input wire logic ref_clk_i,
	// config read port
	input wire logic cfg_rd_i,
	input wire logic [16:0] cfg_addr_i,
	input wire logic [7:0] prot_val_i,
	input wire logic [7:0] sec_val_i,
	output logic [7:0] cfg_data_o
);
	logic tog_q = 1'b0;
	always_ff @(posedge ref_clk_i)
		tog_q <= ~tog_q;
	// idle data changes every cycle so a stale sample shows
	always_comb
	begin
		cfg_data_o = {8{tog_q}} ^ 8'h5A;
		if (cfg_rd_i && cfg_addr_i == flash_map_pkg::PROT_BYTE_ADDR)
			cfg_data_o = prot_val_i;
		else if (cfg_rd_i && cfg_addr_i == flash_map_pkg::SEC_BYTE_ADDR)
			cfg_data_o = sec_val_i;
	end
endmodule

// *** bench/flash_map_decode_tb_top.sv ***
// testbench for the flash map and protection decode
// assumes the config model answers the reset load reads
`timescale 1ns/1ps
module flash_map_decode_tb_top;
	logic clk = 1'b0;
	logic rstn = 1'b0;
	logic req = 1'b0;
	logic [15:0] addr = 16'h0000;
	logic [5:0] page = 6'h38;
	logic [7:0] prot_val = 8'hFF;
	logic [7:0] sec_val = 8'hFF;
	logic cfg_rd;
	logic [16:0] cfg_addr;
	logic [7:0] cfg_data;
	logic hold;
	flash_map_pkg::decode_s dec;
	logic [7:0] prot;
	logic [7:0] sec;
	int fails = 0;
	int n_checks = 0;
	always #50 clk = ~clk;
	flash_map_decode flash_map_decode_inst (.ref_clk_i(clk), .rstn_i(rstn), .req_i(req), .addr_i(addr),
		.page_select_register_i(page), .cfg_rd_o(cfg_rd), .cfg_addr_o(cfg_addr), .cfg_data_i(cfg_data),
		.hold_core_o(hold), .dec_o(dec), .array_protection_register_o(prot), .array_security_register_o(sec));
	cfg_field_model cfg_field_model_inst (.ref_clk_i(clk), .cfg_rd_i(cfg_rd), .cfg_addr_i(cfg_addr),
		.prot_val_i(prot_val), .sec_val_i(sec_val), .cfg_data_o(cfg_data));
	// ****************
	// shared tasks
	// ****************
	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp)
		begin
			fails++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic close_out();
		if (fails == 0 && n_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic do_reset(input logic [7:0] p, input logic [7:0] s);
		int i;
		prot_val = p;
		sec_val = s;
		@(negedge clk);
		rstn = 1'b0;
		req = 1'b0;
		repeat (5) @(negedge clk);
		chk("hold", hold, 1);
		rstn = 1'b1;
		i = 0;
		while (hold !== 1'b0 && i < 10)
		begin
			@(negedge clk);
			i++;
			if (i == 1)
				chk("rd prot", {cfg_rd, cfg_addr}, {1'b1, flash_map_pkg::PROT_BYTE_ADDR});
			if (i == 2)
				chk("rd sec", {cfg_rd, cfg_addr}, {1'b1, flash_map_pkg::SEC_BYTE_ADDR});
		end
		chk("load", i, 3);
		chk("rd idle", cfg_rd, 0);
		chk("prot", prot, p);
		chk("sec", sec, s);
		if (i == 10)
			close_out();
	endtask
	task automatic probe(input logic [15:0] a, input logic [5:0] pg);
		req = 1'b1;
		addr = a;
		page = pg;
		@(negedge clk);
	endtask
	task automatic map(input logic [15:0] a, input logic [5:0] pg, input logic v, input logic [16:0] arr);
		probe(a, pg);
		chk("valid", dec.valid, v);
		if (v)
			chk("array", dec.array_addr, arr);
	endtask
	task automatic area(input logic [15:0] a, input logic [5:0] pg, input logic lo, input logic hi);
		probe(a, pg);
		chk("low", dec.in_low_area, lo);
		chk("high", dec.in_high_area, hi);
		chk("hit", dec.prot_hit, lo | hi);
	endtask
	// ****************
	// scenarios
	// ****************
	task automatic t_windows();
		map(16'h4000, 6'h38, 1'b1, 17'h18000);
		map(16'h7FFF, 6'h3B, 1'b1, 17'h1BFFF);
		map(16'hC000, 6'h3A, 1'b1, 17'h1C000);
		map(16'hFFFF, 6'h39, 1'b1, 17'h1FFFF);
		map(16'h3FFF, 6'h3F, 1'b0, 17'h0);
		map(16'h8000, 6'h37, 1'b0, 17'h0);
		req = 1'b0;
		@(negedge clk);
		chk("idle", dec.valid, 0);
	endtask
	task automatic t_pages();
		for (int p = 0; p < 8; p++)
		begin
			map(16'h8000, 6'h38 + 6'(p), 1'b1, {3'(p), 14'h0000});
			map(16'hBFFF, 6'h38 + 6'(p), 1'b1, {3'(p), 14'h3FFF});
		end
	endtask
	task automatic t_field();
		logic [15:0] al [9] = '{16'hFEFF, 16'hFF00, 16'hFF07, 16'hFF08, 16'hFF0C, 16'hFF0D, 16'hFF0E,
			16'hFF0F, 16'hFF10};
		logic [3:0] fl [9] = '{4'h0, 4'h8, 4'h8, 4'h1, 4'h1, 4'h4, 4'h1, 4'h2, 4'h0};
		for (int i = 0; i < 9; i++)
		begin
			probe(al[i], 6'h3C);
			chk("field", {dec.in_key, dec.in_prot_byte, dec.in_sec_byte, dec.in_reserved}, fl[i]);
		end
		probe(16'hBF07, 6'h3F);
		chk("alias key", dec.in_key, 1);
	endtask
	task automatic t_areas_a();
		area(16'h5FFF, 6'h38, 1'b1, 1'b0);
		area(16'h6000, 6'h38, 1'b0, 1'b0);
		area(16'h9FFF, 6'h3E, 1'b1, 1'b0);
		area(16'hF800, 6'h38, 1'b0, 1'b1);
		area(16'hF7FF, 6'h38, 1'b0, 1'b0);
		area(16'hB800, 6'h3F, 1'b0, 1'b1);
		area(16'hB7FF, 6'h3F, 1'b0, 1'b0);
	endtask
	task automatic t_areas_b();
		area(16'hC000, 6'h38, 1'b0, 1'b1);
		area(16'h8000, 6'h3F, 1'b0, 1'b1);
		area(16'h43FF, 6'h38, 1'b1, 1'b0);
		area(16'h4400, 6'h38, 1'b0, 1'b0);
		area(16'h8000, 6'h3D, 1'b0, 1'b0);
	endtask
	task automatic t_whole();
		do_reset(8'h7F, 8'h00);
		probe(16'h8000, 6'h38);
		chk("whole", dec.prot_hit, 1);
		probe(16'h6000, 6'h38);
		chk("whole", dec.prot_hit, 1);
		do_reset(8'hFF, 8'hFF);
		probe(16'h8000, 6'h38);
		chk("open", dec.prot_hit, 0);
	endtask
	initial
	begin
		do_reset(8'hC3, 8'hA5);
		t_windows();
		t_pages();
		t_field();
		t_areas_a();
		do_reset(8'hD8, 8'h3C);
		t_areas_b();
		t_whole();
		close_out();
	end
endmodule
